// file: logic/cbs_chan_b_pins.v
// Channel B loss indicator, lane jog, power down and reference select logic
//
// Notes on behaviour
// - The loss pin is low while signal is seen on the receive input and high once it is lost.
// - When enabled, loss is declared at or below 75 mVpp and cleared above 150 mVpp.
// - Software may switch the loss pin to show other internal states live instead.
// - While device reset is held the loss pin is driven low.
// - The loss pin floats during pin power down and during register power down.
// - Every rising or falling edge of the jog pin rotates the receive lane order one step.
// - Channel B is powered down while its power-down pin is low and runs when it is high.
// - Use of reference clock zero per channel is set by software or by the per-channel pins.
// - Reference clock one can serve one or both channels, selected by software or by the source select pin.
// - The source select pin picks clock zero when low, clock one when high; zero is default.
// - The block answers management accesses only when the port field matches its pins.
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`include "cbs_regs.vh"
module cbs_chan_b_pins #(
  parameter LANES  = 8,
  parameter LANE_W = 3
) (
  input  wire                    clk_i,
  input  wire                    rst_i,
  // Wishbone slave
  input  wire                    cyc_i,
  input  wire                    stb_i,
  input  wire                    we_i,
  input  wire [`CBS_ADR_W-1:0]   adr_i,
  input  wire [3:0]              sel_i,
  input  wire [31:0]             dat_i,
  output reg  [31:0]             dat_o,
  output reg                     ack_o,
  output reg                     irq_o,
  // Pins and front end
  input  wire [`CBS_PORT_W-1:0]  mgmt_port_address_i,
  input  wire [`CBS_LEVEL_W-1:0] high_speed_rx_b_level_i,
  input  wire                    lane_rotate_jog_b_i,
  input  wire                    chan_b_power_down_n_i,
  input  wire                    ref_select_chan_a_i,
  input  wire                    ref_select_chan_b_i,
  input  wire                    ref_source_select_i,
  output reg                     rx_signal_lost_b_o,
  output reg                     rx_signal_lost_b_oe_n_o,
  output reg                     chan_b_powered_down_o,
  output reg                     datapath_reset_b_o,
  output reg                     lane_rotate_step_b_o,
  output reg  [LANE_W-1:0]       lane_index_b_o,
  output reg                     ref_clock_one_a_o,
  output reg                     ref_clock_one_b_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Byte-lane write merge for the low byte, where every field lives
  function [7:0] wr_low;
    input [7:0] old_v;
    input [3:0] sel;
    input [7:0] new_v;
    begin
      wr_low = sel[0] ? new_v : old_v;
    end
  endfunction

  reg  [`CBS_CTRL_W-1:0] ctrl_r;
  reg  [`CBS_IRQ_W-1:0]  irq_stat_r;
  reg  [`CBS_IRQ_W-1:0]  irq_mask_r;
  reg  [`CBS_IRQ_W-1:0]  irq_stat_nxt;
  reg  [LANE_W-1:0]      lane_r;
  reg  [LANE_W-1:0]      lane_nxt;
  reg                    los_q_r;
  reg  [31:0]            rd_nxt;
  reg                    pin_nxt;

  wire                   jog_lvl;
  wire                   jog_chg;
  wire                   pd_n_lvl;
  wire                   pd_n_chg;
  wire [2:0]             ref_pins;
  wire [`CBS_PORT_W-1:0] port_q;
  wire                   los_raw;
  wire                   reg_pd;
  wire                   pd_pin;
  wire                   ch_down;
  wire                   ref1_a;
  wire                   ref1_b;
  wire                   port_hit;
  wire                   req;
  wire                   wr_go;
  wire [6:0]             ofs;
  wire [`CBS_IRQ_W-1:0]  irq_set;
  wire [1:0]             view;
  wire [7:0]             ctrl_wr;
  wire [7:0]             mask_wr;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; power-down pin resets to high so the channel starts up
  cbs_edge_sync #(
    .W       (1),
    .RST_VAL (1'b0)
  ) u_jog_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (lane_rotate_jog_b_i),
    .q_o   (jog_lvl),
    .chg_o (jog_chg)
  );

  cbs_edge_sync #(
    .W       (1),
    .RST_VAL (1'b1)
  ) u_pd_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (chan_b_power_down_n_i),
    .q_o   (pd_n_lvl),
    .chg_o (pd_n_chg)
  );

  cbs_edge_sync #(
    .W       (3),
    .RST_VAL (3'h0)
  ) u_ref_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({ref_source_select_i, ref_select_chan_b_i, ref_select_chan_a_i}),
    .q_o   (ref_pins),
    .chg_o ()
  );

  // Port address straps are static, so a per-bit synchroniser is safe
  cbs_edge_sync #(
    .W       (`CBS_PORT_W),
    .RST_VAL (5'h00)
  ) u_port_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (mgmt_port_address_i),
    .q_o   (port_q),
    .chg_o ()
  );

  ////////////////////////////////////////////////////////////////////////////
  // Loss detection with hysteresis, gated by the enable bit
  cbs_los_hyst u_los (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (ctrl_r[`CBS_CTRL_LOS_EN]),
    .level_i (high_speed_rx_b_level_i),
    .los_o   (los_raw)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Channel state and reference choice
  assign reg_pd  = ctrl_r[`CBS_CTRL_REG_PD];
  assign pd_pin  = ~pd_n_lvl;
  assign ch_down = pd_pin | reg_pd;
  assign view    = ctrl_r[`CBS_CTRL_VIEW_MSB:`CBS_CTRL_VIEW_LSB];

  // Clock one only by software bit or source select; a channel pin forces zero
  assign ref1_a  = ~ref_pins[0] &
                   (ctrl_r[`CBS_CTRL_REF1_A] | ref_pins[2]);
  assign ref1_b  = ~ref_pins[1] &
                   (ctrl_r[`CBS_CTRL_REF1_B] | ref_pins[2]);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode: only our port answers; other ports belong to other devices
  assign port_hit = (adr_i[`CBS_PORT_MSB:`CBS_PORT_LSB] == port_q);
  assign req      = cyc_i & stb_i & port_hit & ~ack_o;
  // Writes land on the edge at which the master samples ack, never earlier
  assign wr_go    = cyc_i & stb_i & we_i & port_hit & ack_o;
  assign ctrl_wr  = wr_low({1'b0, ctrl_r}, sel_i, dat_i[7:0]);
  assign mask_wr  = wr_low({4'h0, irq_mask_r}, sel_i, dat_i[7:0]);
  assign ofs      = {adr_i[6:2], 2'b00};

  // Events: loss edges, rotation, release of the power-down pin
  assign irq_set  = {pd_n_chg & pd_n_lvl,
                     jog_chg,
                     los_q_r & ~los_raw,
                     ~los_q_r & los_raw};

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets of our port read as zero
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (ofs)
      `CBS_OFS_CTRL: begin
        rd_nxt[`CBS_CTRL_W-1:0] = ctrl_r;
        rd_nxt[`CBS_CTRL_DP_RST] = 1'b0;
      end
      `CBS_OFS_STATUS: begin
        rd_nxt[`CBS_STAT_LOS]     = los_raw;
        rd_nxt[`CBS_STAT_PD_PIN]  = pd_pin;
        rd_nxt[`CBS_STAT_CH_DOWN] = ch_down;
        rd_nxt[`CBS_STAT_REF1_A]  = ref1_a;
        rd_nxt[`CBS_STAT_REF1_B]  = ref1_b;
        rd_nxt[`CBS_STAT_LANE_LSB +: LANE_W] = lane_r;
      end
      `CBS_OFS_IRQ_STAT: begin
        rd_nxt[`CBS_IRQ_W-1:0] = irq_stat_r;
      end
      `CBS_OFS_IRQ_MASK: begin
        rd_nxt[`CBS_IRQ_W-1:0] = irq_mask_r;
      end
      default: begin
        rd_nxt = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status: write one clears, a new event in the same cycle wins
  always @* begin
    irq_stat_nxt = irq_stat_r;
    if (wr_go && ofs == `CBS_OFS_IRQ_STAT && sel_i[0]) begin
      irq_stat_nxt = irq_stat_r & ~dat_i[`CBS_IRQ_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | irq_set;
  end

  // Lane counter wraps after the last lane
  always @* begin
    lane_nxt = lane_r;
    if (jog_chg) begin
      if (lane_r == LANES - 1) begin
        lane_nxt = {LANE_W{1'b0}};
      end else begin
        lane_nxt = lane_r + {{(LANE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Value the loss pin shows when it drives
  always @* begin
    case (view)
      `CBS_VIEW_LOS:   pin_nxt = los_raw;
      `CBS_VIEW_DOWN:  pin_nxt = ch_down;
      `CBS_VIEW_JOG:   pin_nxt = jog_lvl;
      `CBS_VIEW_LANE0: pin_nxt = lane_r[0];
      default:         pin_nxt = los_raw;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file and bus answer, one wait cycle then ack
  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r     <= `CBS_CTRL_RST;
      irq_mask_r <= `CBS_IRQ_MASK_RST;
      irq_stat_r <= {`CBS_IRQ_W{1'b0}};
      ack_o      <= 1'b0;
      dat_o      <= 32'h0000_0000;
    end else begin
      ack_o      <= req;
      dat_o      <= req ? rd_nxt : 32'h0000_0000;
      irq_stat_r <= irq_stat_nxt;
      // Datapath reset request bit clears itself after one cycle
      ctrl_r[`CBS_CTRL_DP_RST] <= 1'b0;
      if (wr_go && ofs == `CBS_OFS_CTRL) begin
        ctrl_r <= ctrl_wr[`CBS_CTRL_W-1:0];
      end
      if (wr_go && ofs == `CBS_OFS_IRQ_MASK) begin
        irq_mask_r <= mask_wr[`CBS_IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channel outputs, all registered
  always @(posedge clk_i) begin
    if (rst_i) begin
      los_q_r               <= 1'b0;
      lane_r                <= {LANE_W{1'b0}};
      lane_index_b_o        <= {LANE_W{1'b0}};
      lane_rotate_step_b_o  <= 1'b0;
      chan_b_powered_down_o <= 1'b0;
      datapath_reset_b_o    <= 1'b0;
      ref_clock_one_a_o     <= 1'b0;
      ref_clock_one_b_o     <= 1'b0;
      irq_o                 <= 1'b0;
    end else begin
      los_q_r               <= los_raw;
      lane_r                <= lane_nxt;
      lane_index_b_o        <= lane_nxt;
      lane_rotate_step_b_o  <= jog_chg;
      chan_b_powered_down_o <= ch_down;
      // Software issues this after power-down release is flagged
      datapath_reset_b_o    <= ctrl_r[`CBS_CTRL_DP_RST];
      ref_clock_one_a_o     <= ref1_a;
      ref_clock_one_b_o     <= ref1_b;
      irq_o                 <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loss pin driver; reset wins over power down so the pin is never
  // left floating while the device is held in reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      rx_signal_lost_b_o      <= 1'b0;
      rx_signal_lost_b_oe_n_o <= 1'b0;
    end else if (ch_down) begin
      rx_signal_lost_b_o      <= 1'b0;
      rx_signal_lost_b_oe_n_o <= 1'b1;
    end else begin
      rx_signal_lost_b_o      <= pin_nxt;
      rx_signal_lost_b_oe_n_o <= 1'b0;
    end
  end

endmodule

// file: logic/cbs_regs.vh
// Register offsets, field positions, reset values and thresholds of the channel B pin block
`ifndef CBS_REGS_VH
`define CBS_REGS_VH

// Register byte offsets within the block's port
`define CBS_OFS_CTRL       7'h00
`define CBS_OFS_STATUS     7'h04
`define CBS_OFS_IRQ_STAT   7'h08
`define CBS_OFS_IRQ_MASK   7'h0C

// Address split: low bits pick the register, high field is the port address
`define CBS_ADR_W          12
`define CBS_PORT_LSB       7
`define CBS_PORT_MSB       11
`define CBS_PORT_W         5

// Control register fields
`define CBS_CTRL_LOS_EN    0
`define CBS_CTRL_REG_PD    1
`define CBS_CTRL_VIEW_LSB  2
`define CBS_CTRL_VIEW_MSB  3
`define CBS_CTRL_REF1_A    4
`define CBS_CTRL_REF1_B    5
`define CBS_CTRL_DP_RST    6
`define CBS_CTRL_W         7
`define CBS_CTRL_RST       7'h01

// Status register fields
`define CBS_STAT_LOS       0
`define CBS_STAT_PD_PIN    1
`define CBS_STAT_CH_DOWN   2
`define CBS_STAT_REF1_A    3
`define CBS_STAT_REF1_B    4
`define CBS_STAT_LANE_LSB  5

// Interrupt bits, shared by status and mask
`define CBS_IRQ_LOS_SET    0
`define CBS_IRQ_LOS_CLR    1
`define CBS_IRQ_ROTATE     2
`define CBS_IRQ_PD_REL     3
`define CBS_IRQ_W          4
`define CBS_IRQ_MASK_RST   4'h0

// Views that the loss indicator pin can show
`define CBS_VIEW_LOS       2'h0
`define CBS_VIEW_DOWN      2'h1
`define CBS_VIEW_JOG       2'h2
`define CBS_VIEW_LANE0     2'h3

// Loss detection thresholds in mV peak to peak
`define CBS_LOS_ASSERT_MV   8'h4B
`define CBS_LOS_DEASSERT_MV 8'h96
`define CBS_LEVEL_W         8

`endif

// file: logic/cbs_edge_sync.v
// Two-stage synchroniser with change detection for pin inputs
`timescale 1ns/10ps
module cbs_edge_sync #(
  parameter           W       = 1,
  parameter [W-1:0]   RST_VAL = {W{1'b0}}
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] d_i,
  output wire [W-1:0] q_o,
  output wire         chg_o
);

  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  reg [W-1:0] prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // First stage feeds only the second; comparison uses later stages
  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
      prev_r <= RST_VAL;
    end else begin
      meta_r <= d_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  // Any change between consecutive samples is one pulse
  assign q_o   = sync_r;
  assign chg_o = |(sync_r ^ prev_r);

endmodule

// file: logic/cbs_los_hyst.v
// Loss-of-signal decision with hysteresis on the measured input swing
`timescale 1ns/10ps
`include "cbs_regs.vh"
module cbs_los_hyst #(
  parameter [`CBS_LEVEL_W-1:0] ASSERT_MV   = `CBS_LOS_ASSERT_MV,
  parameter [`CBS_LEVEL_W-1:0] DEASSERT_MV = `CBS_LOS_DEASSERT_MV
) (
  input  wire                    clk_i,
  input  wire                    rst_i,
  input  wire                    en_i,
  input  wire [`CBS_LEVEL_W-1:0] level_i,
  output reg                     los_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Between the thresholds the old decision holds, so noise cannot chatter
  always @(posedge clk_i) begin
    if (rst_i) begin
      los_o <= 1'b0;
    end else if (!en_i) begin
      los_o <= 1'b0;
    end else if (level_i <= ASSERT_MV) begin
      los_o <= 1'b1;
    end else if (level_i > DEASSERT_MV) begin
      los_o <= 1'b0;
    end
  end

endmodule

// file: verif/cbs_chan_b_properties.sv
// Concurrent checks on the ports of the channel B pin block
`timescale 1ns/10ps
`include "cbs_regs.vh"
module cbs_chan_b_chk #(
  parameter LANES  = 8,
  parameter LANE_W = 3
) (
  input wire                   clk_i,
  input wire                   rst_i,
  input wire                   cyc_i,
  input wire                   stb_i,
  input wire [`CBS_ADR_W-1:0]  adr_i,
  input wire [`CBS_PORT_W-1:0] mgmt_port_address_i,
  input wire                   lane_rotate_jog_b_i,
  input wire                   chan_b_power_down_n_i,
  input wire                   ref_select_chan_b_i,
  input wire                   ref_source_select_i,
  input wire                   ack_o,
  input wire                   irq_o,
  input wire                   rx_signal_lost_b_o,
  input wire                   rx_signal_lost_b_oe_n_o,
  input wire                   chan_b_powered_down_o,
  input wire                   datapath_reset_b_o,
  input wire                   lane_rotate_step_b_o,
  input wire [LANE_W-1:0]      lane_index_b_o,
  input wire                   ref_clock_one_b_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ////////////////////////////////////////////////////////////
  // Bus answers only to a held request aimed at our straps
  AST_ACK_REQ: assert property (ack_o |-> $past(cyc_i && stb_i) && !$past(ack_o))
    else $error("ack without a pending request");
  AST_ACK_PORT: assert property (ack_o |-> $past(adr_i[11:7]) == $past(mgmt_port_address_i))
    else $error("ack for a foreign port address");

  // Loss pin is driven low right out of reset, floats when powered down
  AST_RST_LOS: assert property ($fell(rst_i) |-> !rx_signal_lost_b_o && !rx_signal_lost_b_oe_n_o)
    else $error("loss pin not driven low after reset");
  AST_RST_LOW: assert property (disable iff (1'b0) rst_i[*2] |->
    !rx_signal_lost_b_o && !rx_signal_lost_b_oe_n_o)
    else $error("loss pin not driven low during reset");
  AST_PD_FLOAT: assert property ((!chan_b_power_down_n_i)[*6] |->
    rx_signal_lost_b_oe_n_o && chan_b_powered_down_o)
    else $error("loss pin driven while powered down");

  // Every jog edge gives one step, and the index moves only on a step
  AST_JOG_STEP: assert property ($changed(lane_rotate_jog_b_i) |-> ##[3:5] lane_rotate_step_b_o)
    else $error("jog edge without a rotation step");
  AST_IDX_STEP: assert property (lane_rotate_step_b_o |->
    lane_index_b_o == LANE_W'(($past(lane_index_b_o) + 1) % LANES))
    else $error("lane index did not advance by one");
  AST_IDX_HOLD: assert property (!lane_rotate_step_b_o |-> $stable(lane_index_b_o))
    else $error("lane index moved without a step");
  AST_DPR_ONE: assert property (datapath_reset_b_o |=> !datapath_reset_b_o)
    else $error("datapath reset longer than one cycle");

  // Reference choice for channel B follows the pins once synchronised
  AST_REF_ZERO: assert property (ref_select_chan_b_i[*5] |-> !ref_clock_one_b_o)
    else $error("clock one used although pin forces clock zero");
  AST_REF_ONE: assert property ((!ref_select_chan_b_i && ref_source_select_i)[*5] |->
    ref_clock_one_b_o)
    else $error("source select high did not pick clock one");

  // Main scenarios reached
  COV_STEP: cover property (lane_rotate_step_b_o);
  COV_FLOAT: cover property ($rose(rx_signal_lost_b_oe_n_o));
  COV_IRQ: cover property (irq_o ##1 !irq_o);
endmodule

bind cbs_chan_b_pins cbs_chan_b_chk #(
  .LANES  (LANES),
  .LANE_W (LANE_W)
) chk (
  .clk_i                   (clk_i),
  .rst_i                   (rst_i),
  .cyc_i                   (cyc_i),
  .stb_i                   (stb_i),
  .adr_i                   (adr_i),
  .mgmt_port_address_i     (mgmt_port_address_i),
  .lane_rotate_jog_b_i     (lane_rotate_jog_b_i),
  .chan_b_power_down_n_i   (chan_b_power_down_n_i),
  .ref_select_chan_b_i     (ref_select_chan_b_i),
  .ref_source_select_i     (ref_source_select_i),
  .ack_o                   (ack_o),
  .irq_o                   (irq_o),
  .rx_signal_lost_b_o      (rx_signal_lost_b_o),
  .rx_signal_lost_b_oe_n_o (rx_signal_lost_b_oe_n_o),
  .chan_b_powered_down_o   (chan_b_powered_down_o),
  .datapath_reset_b_o      (datapath_reset_b_o),
  .lane_rotate_step_b_o    (lane_rotate_step_b_o),
  .lane_index_b_o          (lane_index_b_o),
  .ref_clock_one_b_o       (ref_clock_one_b_o)
);

// file: verif/cbs_host_model.sv
// Board-side controller model that drives the channel B control pins
`timescale 1ns/10ps
module cbs_host_model (
  input  wire        clk_i,
  output logic       jog_o,
  output logic       pd_n_o,
  output logic       sel_a_o,
  output logic       sel_b_o,
  output logic       src_o,
  output logic [7:0] level_o
);
  // Powered up, clock zero, no signal at time zero
  initial begin
    jog_o   = 1'b0;
    pd_n_o  = 1'b1;
    sel_a_o = 1'b0;
    sel_b_o = 1'b0;
    src_o   = 1'b0;
    level_o = 8'h00;
  end

  // One jog edge; the level is held at least two cycles so no edge merges
  task automatic jog(input int gap);
    @(posedge clk_i);
    jog_o <= ~jog_o;
    repeat ((gap < 2) ? 2 : gap) @(posedge clk_i);
  endtask

  // Static pins and measured swing change together after an edge
  task automatic pins(input logic pd_n, a, b, s, input logic [7:0] lvl);
    @(posedge clk_i);
    pd_n_o  <= pd_n;
    sel_a_o <= a;
    sel_b_o <= b;
    src_o   <= s;
    level_o <= lvl;
  endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the channel B pin block
`timescale 1ns/10ps
`include "cbs_regs.vh"
module tb_top;
  localparam [4:0] PORT = 5'h0B;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
  logic [11:0] adr_i = 0;
  logic [3:0]  sel_i = 0;
  logic [3:0]  wsel = 4'hF;
  logic [31:0] dat_i = 0, q;
  wire  [31:0] dat_o;
  wire         ack_o, irq_o, los, oe_n, pdn, dpr, step, r1a, r1b;
  wire         jog, pd_n, sa, sb, src;
  wire  [2:0]  idx;
  wire  [7:0]  lvl;
  int          n_fail = 0, comparisons = 0, cycles = 0, n_step = 0, n, l, e_idx;
  int          lv[8] = '{0, 75, -1, 150, 151, -1, 76, 75};
  logic        p_los;

  always #25 clk_i = ~clk_i;

  cbs_host_model host (.clk_i(clk_i), .jog_o(jog), .pd_n_o(pd_n), .sel_a_o(sa),
    .sel_b_o(sb), .src_o(src), .level_o(lvl));
  cbs_chan_b_pins dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .irq_o(irq_o), .mgmt_port_address_i(PORT),
    .high_speed_rx_b_level_i(lvl), .lane_rotate_jog_b_i(jog),
    .chan_b_power_down_n_i(pd_n), .ref_select_chan_a_i(sa), .ref_select_chan_b_i(sb),
    .ref_source_select_i(src), .rx_signal_lost_b_o(los), .rx_signal_lost_b_oe_n_o(oe_n),
    .chan_b_powered_down_o(pdn), .datapath_reset_b_o(dpr), .lane_rotate_step_b_o(step),
    .lane_index_b_o(idx), .ref_clock_one_a_o(r1a), .ref_clock_one_b_o(r1b));

  ////////////////////////////////////////////////////////////
  task tally_and_finish;
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Hysteresis: in the band between thresholds the old decision holds
  function automatic logic los_exp(logic p, int v);
    return (v <= 75) ? 1'b1 : ((v > 150) ? 1'b0 : p);
  endfunction

  // Classic cycle; a foreign port never answers, so give up after four edges
  task automatic wb(input logic w, input logic [4:0] p, input logic [6:0] o,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc_i <= 1; stb_i <= 1; we_i <= w; adr_i <= {p, o}; dat_i <= d; sel_i <= wsel;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && !(p != PORT && k == 4));
    if (p != PORT) chk("foreign_ack", 0, ack_o);
    q = dat_o;
    cyc_i <= 0; stb_i <= 0;
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge clk_i) if (++cycles == 20000) begin
    n_fail++;
    tally_and_finish;
  end

  // Count rotation pulses so each jog edge must show up exactly once
  always @(posedge clk_i) if (step === 1'b1) n_step++;

  ////////////////////////////////////////////////////////////
  initial begin
    n = $urandom(32'ha18c8d1f);
    repeat (15) @(posedge clk_i);
    chk("los_in_reset", 0, los);
    chk("oe_in_reset", 0, oe_n);
    @(posedge clk_i); rst_i <= 0;
    repeat (5) @(posedge clk_i);
    wb(0, PORT, `CBS_OFS_CTRL, 0); chk("ctrl_rst", 32'h0000_0001, q);
    wb(0, PORT, `CBS_OFS_STATUS, 0); chk("stat_rst", 32'h0000_0001, q);
    wb(1, PORT ^ 5'h01, `CBS_OFS_IRQ_MASK, 32'h0000_000F);
    // Byte lane zero disabled: the write is answered but must change nothing
    wsel = 4'h0;
    wb(1, PORT, `CBS_OFS_IRQ_MASK, 32'h0000_000F);
    wsel = 4'hF;
    wb(0, PORT, `CBS_OFS_IRQ_MASK, 0); chk("mask_kept", 0, q);
    wb(0, PORT, 7'h10, 0); chk("unmapped", 0, q);
    // Swing sweep across both thresholds, random values inside the band
    p_los = 1;
    foreach (lv[i]) begin
      l = (lv[i] < 0) ? 76 + $urandom % 75 : lv[i];
      host.pins(1, 0, 0, 0, l[7:0]);
      repeat (4) @(posedge clk_i);
      p_los = los_exp(p_los, l);
      chk("los", p_los, los);
      chk("los_oe", 0, oe_n);
    end
    // Random jog burst, edges three to five cycles apart, interrupt enabled
    wb(1, PORT, `CBS_OFS_IRQ_MASK, 32'h0000_0004);
    n = 1 + $urandom % 12;
    repeat (n) host.jog(2 + $urandom % 3);
    repeat (6) @(posedge clk_i);
    e_idx = n % 8;
    chk("lane", e_idx, idx);
    chk("steps", n, n_step);
    chk("irq_on", 1, irq_o);
    wb(0, PORT, `CBS_OFS_STATUS, 0); chk("stat_lane", e_idx, q[7:5]);
    wb(1, PORT, `CBS_OFS_IRQ_STAT, 32'h0000_0004);
    repeat (2) @(posedge clk_i);
    chk("irq_clr", 0, irq_o);
    wb(1, PORT, `CBS_OFS_IRQ_MASK, 0);
    host.jog(2);
    repeat (6) @(posedge clk_i);
    e_idx = (e_idx + 1) % 8;
    chk("irq_masked", 0, irq_o);
    wb(0, PORT, `CBS_OFS_IRQ_STAT, 0); chk("stat_sticky", 4, q & 4);
    // Other views on the loss pin, and the enable turned off
    for (int v = 0; v < 5; v++) begin
      wb(1, PORT, `CBS_OFS_CTRL, (v == 4) ? 0 : 1 | v << 2);
      repeat (3) @(posedge clk_i);
      chk("view", (v == 0) ? 1 : (v == 2) ? jog : (v == 3) ? e_idx % 2 : 0, los);
    end
    // Pin power down, release, then the datapath reset
    host.pins(0, 0, 0, 0, 0);
    repeat (6) @(posedge clk_i);
    chk("pd_float", 1, oe_n);
    chk("pd_state", 1, pdn);
    host.pins(1, 0, 0, 0, 0);
    repeat (6) @(posedge clk_i);
    chk("pd_drive", 0, oe_n);
    wb(0, PORT, `CBS_OFS_IRQ_STAT, 0); chk("pd_rel", 8, q & 8);
    wb(1, PORT, `CBS_OFS_CTRL, 32'h0000_0041);
    n = 0;
    while (dpr !== 1'b1 && n < 8) begin
      @(posedge clk_i);
      n++;
    end
    chk("dp_reset", 1, dpr);
    wb(1, PORT, `CBS_OFS_CTRL, 32'h0000_0003);
    repeat (3) @(posedge clk_i);
    chk("reg_pd", 1, oe_n);
    // Every pin and software combination of the reference choice
    for (int i = 0; i < 32; i++) begin
      wb(1, PORT, `CBS_OFS_CTRL, 1 | i[4:3] << 4);
      host.pins(1, i[0], i[1], i[2], 0);
      repeat (5) @(posedge clk_i);
      chk("ref_a", ~i[0] & (i[3] | i[2]), r1a);
      chk("ref_b", ~i[1] & (i[4] | i[2]), r1b);
    end
    // Reset outranks power down on the loss pin
    host.pins(0, 0, 0, 0, 0);
    repeat (6) @(posedge clk_i);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    chk("los_rst_pd", 0, los);
    chk("oe_rst_pd", 0, oe_n);
    tally_and_finish;
  end
endmodule
